// >>> mclc_cfg.svh
// Constants for the motor current level control block
`ifndef MCLC_CFG_SVH
`define MCLC_CFG_SVH

// ----------------------------------------------------------------------------
// Command codes on the command port
// ----------------------------------------------------------------------------
`define MCLC_CMD_PEAK 3'h0
`define MCLC_CMD_RUN 3'h1
`define MCLC_CMD_IDLE 3'h2
`define MCLC_CMD_DELAY 3'h3
`define MCLC_CMD_FAULT 3'h4

// ----------------------------------------------------------------------------
// Field layout of the link fault word
// ----------------------------------------------------------------------------
`define MCLC_FLT_PARITY 0
`define MCLC_FLT_FRAMING 1
`define MCLC_FLT_NOISE 2
`define MCLC_FLT_OVERRUN 3
`define MCLC_FLT_RX_FULL 4
`define MCLC_FLT_TX_FULL 5
`define MCLC_FLT_BAD_OP 6
`define MCLC_FLT_TX_TMO 7
`define MCLC_FAULT_RST 8'h00

// ----------------------------------------------------------------------------
// Current settings in units of 0.01 A, reset values
// ----------------------------------------------------------------------------
`define MCLC_CUR_W 11
`define MCLC_RUN_RST 11'h0_64
`define MCLC_PEAK_RST 11'h0_64
`define MCLC_IDLE_RST 11'h0_32
`define MCLC_CUR_MAX_DFLT 11'h3_E8

// ----------------------------------------------------------------------------
// Delay settings in units of 0.01 s, range 0.00 to 10.00 s
// ----------------------------------------------------------------------------
`define MCLC_DLY_W 10
`define MCLC_DLY_MAX 10'h3_E8
`define MCLC_DLY_RST 10'h0_32
`define MCLC_TICK_NS 10000000
`define MCLC_CLK_NS 5
`define MCLC_TICK_CYC (`MCLC_TICK_NS / `MCLC_CLK_NS)

`endif

// >>> mclc_pkg.sv
// Types shared by the motor current level control block
package mclc_pkg;
  typedef logic [10:0] mclc_cur_t;
  typedef logic [9:0] mclc_dly_t;
  typedef enum logic [2:0] {
    MCLC_RUN = 3'b001,
    MCLC_WAIT = 3'b010,
    MCLC_IDLE = 3'b100
  } mclc_state_t;
endpackage : mclc_pkg

// >>> mclc_tick_if.sv
// Interface carrying the delay timer hand-off
`timescale 1ns/10ps
`default_nettype none
interface mclc_tick_if;
  logic restart;
  logic [9:0] delay;
  logic expired;
  modport timer (input restart, input delay, output expired);
  modport ctrl (output restart, output delay, input expired);
endinterface : mclc_tick_if
`default_nettype wire

// >>> mclc_delay_timer.sv
// Idle current delay timer in 10 ms ticks
`timescale 1ns/10ps
`default_nettype none
`include "mclc_cfg.svh"
module mclc_delay_timer
  import mclc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `MCLC_TICK_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control side
  mclc_tick_if.timer tif
);
  logic [31:0] pre_r, pre_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  logic exp_r, exp_nxt;

  // ----------------------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------------------
  // Restart reloads from zero so a zero delay expires on the next cycle
  always_comb begin
    pre_nxt = pre_r;
    cnt_nxt = cnt_r;
    exp_nxt = exp_r;
    if (tif.restart) begin
      pre_nxt = 32'h0000_0000;
      cnt_nxt = 10'h000;
      exp_nxt = 1'b0;
    end else if (!exp_r) begin
      if (cnt_r >= tif.delay) begin
        exp_nxt = 1'b1;
      end else if (pre_r >= 32'(TICK_CYC - 1)) begin
        pre_nxt = 32'h0000_0000;
        cnt_nxt = cnt_r + 10'h001;
      end else begin
        pre_nxt = pre_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 32'h0000_0000;
      cnt_r <= 10'h000;
      exp_r <= 1'b1;
    end else begin
      pre_r <= pre_nxt;
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign tif.expired = exp_r;
endmodule : mclc_delay_timer
`default_nettype wire

// >>> mclc_top.sv
// Motor current level control: settings, idle drop, link fault word
`timescale 1ns/10ps
`default_nettype none
`include "mclc_cfg.svh"
module mclc_top
  import mclc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `MCLC_TICK_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Variant straps and configuration
  input wire logic clamp_variant,
  input wire logic servo_variant,
  input wire logic [10:0] motor_max_current,
  input wire logic pulse_dir_mode,
  // Command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_has_param,
  input wire logic [15:0] cmd_param,
  output logic rsp_valid,
  output logic rsp_reject,
  output logic [15:0] rsp_data,
  // Motion events
  input wire logic step_pulse,
  input wire logic move_done,
  // Link fault events, one bit per fault kind
  input wire logic [7:0] link_fault_set,
  input wire logic link_fault_clr,
  // Drive outputs
  output logic [10:0] motor_current,
  output logic current_is_rms,
  output logic fault_report_word,
  output logic status_lamp
);
  mclc_tick_if tif ();

  mclc_cur_t peak_torque_current_r, peak_torque_current_nxt;
  mclc_cur_t running_current_level_r, running_current_level_nxt;
  mclc_cur_t standstill_current_r, standstill_current_nxt;
  mclc_dly_t hold_delay_time_r, hold_delay_time_nxt;
  logic [7:0] link_fault_word_r, link_fault_word_nxt;
  logic rsp_valid_r, rsp_valid_nxt;
  logic rsp_reject_r, rsp_reject_nxt;
  logic [15:0] rsp_data_r, rsp_data_nxt;
  mclc_state_t state_r, state_nxt;
  logic moving_r, moving_nxt;
  logic [10:0] motor_current_r, motor_current_nxt;
  logic rms_r, rms_nxt;
  logic fault_r, fault_nxt;
  logic restart;
  mclc_cur_t par_cur;
  mclc_cur_t run_lim;

  // Widen a current setting for the response bus
  function automatic logic [15:0] mclc_widen(input mclc_cur_t v);
    mclc_widen = {5'h00, v};
  endfunction : mclc_widen

  // Clip a value to a limit
  function automatic mclc_cur_t mclc_clip(input mclc_cur_t v, input mclc_cur_t lim);
    mclc_clip = (v > lim) ? lim : v;
  endfunction : mclc_clip

  // ----------------------------------------------------------------------------
  // Settings and command answers
  // ----------------------------------------------------------------------------
  // Parameters above the field width saturate rather than wrap
  assign par_cur = (cmd_param[15:11] != 5'h00) ? 11'h7_FF : cmd_param[10:0];
  assign run_lim = mclc_clip(par_cur, motor_max_current);

  always_comb begin
    peak_torque_current_nxt = peak_torque_current_r;
    running_current_level_nxt = running_current_level_r;
    standstill_current_nxt = standstill_current_r;
    hold_delay_time_nxt = hold_delay_time_r;
    rsp_valid_nxt = 1'b0;
    rsp_reject_nxt = 1'b0;
    rsp_data_nxt = rsp_data_r;
    if (cmd_valid) begin
      rsp_valid_nxt = 1'b1;
      case (cmd_code)
        `MCLC_CMD_PEAK: begin
          rsp_data_nxt = mclc_widen(peak_torque_current_r);
          if (cmd_has_param) begin
            if (par_cur < running_current_level_r) begin
              rsp_reject_nxt = 1'b1;
            end else begin
              peak_torque_current_nxt = par_cur;
            end
          end
        end
        `MCLC_CMD_RUN: begin
          rsp_data_nxt = mclc_widen(running_current_level_r);
          if (cmd_has_param) begin
            running_current_level_nxt = run_lim;
            if (!clamp_variant) begin
              standstill_current_nxt = {1'b0, run_lim[10:1]};
            end else if (run_lim < standstill_current_r) begin
              standstill_current_nxt = run_lim;
            end
          end
        end
        `MCLC_CMD_IDLE: begin
          rsp_data_nxt = mclc_widen(standstill_current_r);
          if (cmd_has_param) begin
            standstill_current_nxt = mclc_clip(par_cur, running_current_level_r);
          end
        end
        `MCLC_CMD_DELAY: begin
          rsp_data_nxt = {6'h00, hold_delay_time_r};
          if (cmd_has_param) begin
            if (cmd_param > {6'h00, `MCLC_DLY_MAX}) begin
              rsp_reject_nxt = 1'b1;
            end else begin
              hold_delay_time_nxt = cmd_param[9:0];
            end
          end
        end
        `MCLC_CMD_FAULT: begin
          // Read only: a parameter is ignored
          rsp_data_nxt = {8'h00, link_fault_word_r};
        end
        default: begin
          rsp_reject_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      peak_torque_current_r <= `MCLC_PEAK_RST;
      running_current_level_r <= `MCLC_RUN_RST;
      standstill_current_r <= `MCLC_IDLE_RST;
      hold_delay_time_r <= `MCLC_DLY_RST;
      rsp_valid_r <= 1'b0;
      rsp_reject_r <= 1'b0;
      rsp_data_r <= 16'h0000;
    end else begin
      peak_torque_current_r <= peak_torque_current_nxt;
      running_current_level_r <= running_current_level_nxt;
      standstill_current_r <= standstill_current_nxt;
      hold_delay_time_r <= hold_delay_time_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_reject_r <= rsp_reject_nxt;
      rsp_data_r <= rsp_data_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Link fault word
  // ----------------------------------------------------------------------------
  // Set wins over clear so a fault in the clearing cycle survives
  always_comb begin
    link_fault_word_nxt = link_fault_word_r;
    if (link_fault_clr) begin
      link_fault_word_nxt = 8'h00;
    end
    link_fault_word_nxt = link_fault_word_nxt | link_fault_set;
    fault_nxt = (link_fault_word_nxt != 8'h00);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      link_fault_word_r <= `MCLC_FAULT_RST;
      fault_r <= 1'b0;
    end else begin
      link_fault_word_r <= link_fault_word_nxt;
      fault_r <= fault_nxt;
    end
  end

  // ----------------------------------------------------------------------------
  // Running to idle sequencing
  // ----------------------------------------------------------------------------
  // Step pulses only restart the timer in pulse and direction mode
  assign restart = (step_pulse && pulse_dir_mode) || (move_done && moving_r);
  assign tif.restart = restart;
  assign tif.delay = hold_delay_time_r;

  mclc_delay_timer #(.TICK_CYC(TICK_CYC)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tif(tif)
  );

  always_comb begin
    state_nxt = state_r;
    moving_nxt = moving_r;
    case (state_r)
      MCLC_RUN: begin
        if (restart) begin
          state_nxt = MCLC_WAIT;
          moving_nxt = 1'b0;
        end
      end
      MCLC_WAIT: begin
        if (tif.expired && !restart) begin
          state_nxt = MCLC_IDLE;
        end
      end
      MCLC_IDLE: begin
        if (step_pulse) begin
          state_nxt = pulse_dir_mode ? MCLC_WAIT : MCLC_RUN;
          moving_nxt = !pulse_dir_mode;
        end
      end
      default: begin
        state_nxt = MCLC_IDLE;
      end
    endcase
    if (step_pulse && !pulse_dir_mode) begin
      moving_nxt = 1'b1;
      state_nxt = MCLC_RUN;
    end
    // Peak current applies only while an indexed move is under way
    if (state_nxt == MCLC_IDLE) begin
      motor_current_nxt = standstill_current_r;
    end else if (moving_nxt && !pulse_dir_mode && !servo_variant) begin
      motor_current_nxt = peak_torque_current_r;
    end else begin
      motor_current_nxt = running_current_level_r;
    end
    rms_nxt = servo_variant;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MCLC_IDLE;
      moving_r <= 1'b0;
      motor_current_r <= `MCLC_IDLE_RST;
      rms_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      moving_r <= moving_nxt;
      motor_current_r <= motor_current_nxt;
      rms_r <= rms_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign rsp_valid = rsp_valid_r;
  assign rsp_reject = rsp_reject_r;
  assign rsp_data = rsp_data_r;
  assign motor_current = motor_current_r;
  assign current_is_rms = rms_r;
  assign fault_report_word = fault_r;
  assign status_lamp = fault_r;
endmodule : mclc_top
`default_nettype wire

// >>> mclc_host_model.sv
// Host controller model driving the command port
`timescale 1ns/10ps
`default_nettype none
module mclc_host_model (
  // Clock
  input wire logic mclk,
  // Command request
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic cmd_has_param,
  output logic [15:0] cmd_param,
  // Response
  input wire logic rsp_valid,
  input wire logic rsp_reject,
  input wire logic [15:0] rsp_data
);
  // Quiet port at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_has_param = 1'b0;
    cmd_param = 16'h0000;
  end

  // One request held over its taking edge, answer read once settled
  task automatic req(input logic [2:0] c, input logic h, input logic [15:0] p,
                     output logic v, output logic r, output logic [15:0] d);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_has_param <= h;
    cmd_param <= p;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_param <= ~p; // Stale data must never look valid
    #1;
    v = rsp_valid;
    r = rsp_reject;
    d = rsp_data;
  endtask : req
endmodule : mclc_host_model
`default_nettype wire

// >>> mclc_top_assertions.sv
// Concurrent checks on the motor current level control ports
`timescale 1ns/10ps
`default_nettype none
`include "mclc_cfg.svh"
module mclc_top_assertions #(
  parameter int unsigned TICK_CYC = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_has_param,
  input wire logic [15:0] cmd_param,
  input wire logic rsp_valid,
  input wire logic rsp_reject,
  input wire logic [15:0] rsp_data,
  // Variant and fault lines
  input wire logic servo_variant,
  input wire logic current_is_rms,
  input wire logic [7:0] link_fault_set,
  input wire logic link_fault_clr,
  input wire logic fault_report_word,
  input wire logic status_lamp
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Every command answered exactly one cycle later, never otherwise
  a_rsp_next_cycle: assert property (cmd_valid |=> rsp_valid)
    else $error("command not answered one cycle later");
  a_rsp_only_answer: assert property (!cmd_valid |=> !rsp_valid)
    else $error("response without a command");
  a_reject_with_valid: assert property (rsp_reject |-> rsp_valid)
    else $error("reject outside a response");
  a_delay_cap_rej: assert property (cmd_valid && cmd_code == `MCLC_CMD_DELAY && cmd_has_param
    && cmd_param > 16'd1000 |=> rsp_reject) else $error("delay above ten seconds taken");
  a_bad_code_rej: assert property (cmd_valid && cmd_code > `MCLC_CMD_FAULT |=> rsp_reject)
    else $error("unknown command code taken");
  // Two queries of one stored setting with an empty cycle between give one answer
  // Fault word left out: link events may change it between the two queries
  a_query_same: assert property ((cmd_valid && !cmd_has_param && cmd_code < `MCLC_CMD_FAULT) ##1 !cmd_valid
    ##1 (cmd_valid && !cmd_has_param && cmd_code == $past(cmd_code, 2))
    |=> rsp_data == $past(rsp_data, 2)) else $error("query changed value");
  a_fault_lamp: assert property (|link_fault_set |=> fault_report_word && status_lamp)
    else $error("fault not shown on report or lamp");
  a_clear_dark: assert property (link_fault_clr && link_fault_set == 8'h00
    |=> !fault_report_word && !status_lamp) else $error("fault indication after clear");
  a_rms_flag: assert property (servo_variant |=> current_is_rms)
    else $error("servo strap without rms flag");
endmodule : mclc_top_assertions
bind mclc_top mclc_top_assertions #(.TICK_CYC(TICK_CYC)) i_mclc_top_assertions (
  .mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
  .cmd_has_param(cmd_has_param), .cmd_param(cmd_param), .rsp_valid(rsp_valid),
  .rsp_reject(rsp_reject), .rsp_data(rsp_data), .servo_variant(servo_variant),
  .current_is_rms(current_is_rms), .link_fault_set(link_fault_set), .link_fault_clr(link_fault_clr),
  .fault_report_word(fault_report_word), .status_lamp(status_lamp)
);
`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the motor current level control block
`timescale 1ns/10ps
`default_nettype none
`include "mclc_cfg.svh"
`define CHK(n, e, s) chk(n, 16'(e), 16'(s))
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic clamp_variant = 1'b0;
  logic servo_variant = 1'b0;
  logic pulse_dir_mode = 1'b0;
  logic step_pulse = 1'b0;
  logic move_done = 1'b0;
  logic [10:0] motor_max_current = `MCLC_CUR_MAX_DFLT;
  logic [7:0] link_fault_set = 8'h00;
  logic link_fault_clr = 1'b0;
  logic cmd_valid, cmd_has_param, rsp_valid, rsp_reject, current_is_rms, fault_report_word, status_lamp;
  logic [2:0] cmd_code;
  logic [15:0] cmd_param, rsp_data, d;
  logic [10:0] motor_current;
  logic v, r;
  int miscompares = 0;
  int total_checks = 0;

  always #2.5 mclk = ~mclk;

  // Short tick keeps the hold delay to a few cycles
  mclc_top #(.TICK_CYC(4)) i_mclc_top (.mclk(mclk), .rst_n(rst_n), .clamp_variant(clamp_variant),
    .servo_variant(servo_variant), .motor_max_current(motor_max_current), .pulse_dir_mode(pulse_dir_mode),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_has_param(cmd_has_param), .cmd_param(cmd_param),
    .rsp_valid(rsp_valid), .rsp_reject(rsp_reject), .rsp_data(rsp_data), .step_pulse(step_pulse),
    .move_done(move_done), .link_fault_set(link_fault_set), .link_fault_clr(link_fault_clr),
    .motor_current(motor_current), .current_is_rms(current_is_rms),
    .fault_report_word(fault_report_word), .status_lamp(status_lamp));
  mclc_host_model i_mclc_host_model (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_has_param(cmd_has_param), .cmd_param(cmd_param), .rsp_valid(rsp_valid),
    .rsp_reject(rsp_reject), .rsp_data(rsp_data));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Command with handshake and refusal checked
  task automatic cmd(input logic [2:0] c, input logic h, input logic [15:0] p, input logic er);
    i_mclc_host_model.req(c, h, p, v, r, d);
    `CHK("rsp_valid", 1'b1, v);
    `CHK("rsp_reject", er, r);
  endtask : cmd

  task automatic query(input logic [2:0] c, input logic [15:0] e);
    cmd(c, 1'b0, 16'h0000, 1'b0);
    `CHK("rsp_data", e, d);
  endtask : query

  // Idle cycles, then look once outputs settle
  task automatic idle_chk(input int n, input logic [10:0] e);
    repeat (n) @(posedge mclk);
    #1;
    `CHK("motor_current", e, motor_current);
  endtask : idle_chk

  task automatic pulse_step;
    @(posedge mclk);
    step_pulse <= 1'b1;
    @(posedge mclk);
    step_pulse <= 1'b0;
  endtask : pulse_step

  task automatic print_verdict;
    if (miscompares == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // Hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    query(`MCLC_CMD_PEAK, 16'h0064);
    query(`MCLC_CMD_RUN, 16'h0064);
    query(`MCLC_CMD_IDLE, 16'h0032);
    query(`MCLC_CMD_DELAY, 16'h0032);
    query(`MCLC_CMD_FAULT, 16'h0000);
    cmd(`MCLC_CMD_RUN, 1'b1, 16'd300, 1'b0);
    query(`MCLC_CMD_IDLE, 16'd150);
    cmd(`MCLC_CMD_IDLE, 1'b1, 16'd120, 1'b0);
    query(`MCLC_CMD_IDLE, 16'd120);
    cmd(`MCLC_CMD_PEAK, 1'b1, 16'd299, 1'b1);
    query(`MCLC_CMD_PEAK, 16'h0064);
    cmd(`MCLC_CMD_PEAK, 1'b1, 16'd300, 1'b0);
    cmd(`MCLC_CMD_PEAK, 1'b1, 16'd400, 1'b0);
    query(`MCLC_CMD_PEAK, 16'd400);
    cmd(`MCLC_CMD_DELAY, 1'b1, 16'd1001, 1'b1);
    cmd(`MCLC_CMD_DELAY, 1'b1, 16'd1000, 1'b0);
    cmd(`MCLC_CMD_DELAY, 1'b1, 16'd2, 1'b0);
    query(`MCLC_CMD_DELAY, 16'd2);
    query(`MCLC_CMD_DELAY, 16'd2);
    for (int c = 5; c < 8; c++) begin
      cmd(3'(c), 1'b0, 16'h0000, 1'b1);
    end
    // Clamp variant pulls idle down only when running drops below it
    @(posedge mclk);
    clamp_variant <= 1'b1;
    cmd(`MCLC_CMD_IDLE, 1'b1, 16'd100, 1'b0);
    cmd(`MCLC_CMD_RUN, 1'b1, 16'd80, 1'b0);
    query(`MCLC_CMD_IDLE, 16'd80);
    cmd(`MCLC_CMD_RUN, 1'b1, 16'd300, 1'b0);
    query(`MCLC_CMD_IDLE, 16'd80);
    // Second step restarts the eight-cycle hold; peak of 400 must not appear
    @(posedge mclk);
    clamp_variant <= 1'b0;
    pulse_dir_mode <= 1'b1;
    pulse_step();
    idle_chk(6, 11'd300);
    pulse_step();
    idle_chk(7, 11'd300);
    idle_chk(8, 11'd80);
    // Indexed move: peak while moving, running after move done, idle after the hold
    @(posedge mclk);
    pulse_dir_mode <= 1'b0;
    pulse_step();
    idle_chk(0, 11'd400);
    @(posedge mclk);
    move_done <= 1'b1;
    @(posedge mclk);
    move_done <= 1'b0;
    idle_chk(8, 11'd300);
    idle_chk(2, 11'd80);
    // Each fault bit lands in its own place of the word
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      link_fault_set <= 8'h01 << i;
      @(posedge mclk);
      link_fault_set <= 8'h00;
      query(`MCLC_CMD_FAULT, 16'h0001 << i);
      `CHK("status_lamp", 1'b1, status_lamp);
      `CHK("fault_report_word", 1'b1, fault_report_word);
      @(posedge mclk);
      link_fault_clr <= 1'b1;
      @(posedge mclk);
      link_fault_clr <= 1'b0;
    end
    query(`MCLC_CMD_FAULT, 16'h0000);
    `CHK("fault_report_word", 1'b0, fault_report_word);
    // A fault arriving with the clear survives it, older bits do not
    @(posedge mclk);
    link_fault_set <= 8'h01;
    @(posedge mclk);
    link_fault_set <= 8'h40;
    link_fault_clr <= 1'b1;
    @(posedge mclk);
    link_fault_set <= 8'h00;
    link_fault_clr <= 1'b0;
    query(`MCLC_CMD_FAULT, 16'h0040);
    `CHK("status_lamp", 1'b1, status_lamp);
    @(posedge mclk);
    servo_variant <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    `CHK("current_is_rms", 1'b1, current_is_rms);
    // Servo move runs on the continuous limit, never the peak
    pulse_step();
    idle_chk(0, 11'd300);
    // Configured motor maximum caps a running write
    @(posedge mclk);
    motor_max_current <= 11'd200;
    cmd(`MCLC_CMD_RUN, 1'b1, 16'd300, 1'b0);
    query(`MCLC_CMD_RUN, 16'd200);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
